// ### rtl/fdio_pkg.sv
// package for the four bit digital io port: widths, timing counts and carrier types
package fdio_pkg;

  // ****************************************************************
  // widths
  // ****************************************************************
  localparam int unsigned NUM_BITS   = 4;
  localparam int unsigned SEL_W      = 2;
  localparam int unsigned BYTE_W     = 8;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int unsigned CLK_HZ        = 50_000_000;
  localparam int unsigned FILT_TIME_NS  = 1000;
  // least time: round up, never below one cycle
  localparam int unsigned FILT_CYC_RAW  = (FILT_TIME_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned FILT_CYCLES   = (FILT_CYC_RAW < 1) ? 1 : FILT_CYC_RAW;
  localparam int unsigned CNT_W         = 6;
  localparam logic [CNT_W-1:0] FILT_LAST = CNT_W'(FILT_CYCLES - 1);

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [NUM_BITS-1:0] OUT_RESET  = 4'h0;
  localparam logic [NUM_BITS-1:0] IN_RESET   = 4'h0;
  localparam logic [CNT_W-1:0]    CNT_RESET  = 6'h00;
  localparam logic [BYTE_W-1:0]   BYTE_RESET = 8'h00;

  // ****************************************************************
  // carriers
  // ****************************************************************
  typedef struct packed {
    logic              bit_wr;
    logic              byte_wr;
    logic [SEL_W-1:0]  sel;
    logic [BYTE_W-1:0] data;
  } fdio_wr_t;

  typedef struct packed {
    logic              bit_rd;
    logic              byte_rd;
    logic [SEL_W-1:0]  sel;
  } fdio_rd_t;

endpackage

// ### rtl/fdio_port.sv
// four bit digital io port: filtered inputs, bit and byte reads, bit and byte writes
`timescale 1ns/1ns

// What this block does
// - Four input pins are sampled and addressed as input positions zero to three.
// - A single-bit read returns 1 when the selected input is on and 0 when it is off.
// - A byte read packs input zero into bit zero up to input three in bit three, giving 0 to 15.
// - A filter select chooses between bypassing the inputs and a one microsecond filter.
// - Four output pins are driven and addressed as output positions zero to three.
// - A single-bit write of 1 turns the selected output on and a write of 0 turns it off.
// - A byte write drives output zero from bit zero up to output three from bit three.
module fdio_port
  import fdio_pkg::*;
(
  // clock and reset
  input  wire logic                        clk,
  input  wire logic                        reset,
  // configuration
  input  wire logic                        filter_en,
  // pins
  input  wire logic [fdio_pkg::NUM_BITS-1:0] din_pins,
  output logic      [fdio_pkg::NUM_BITS-1:0] dout_pins,
  // software access
  input  fdio_pkg::fdio_wr_t               wr,
  input  fdio_pkg::fdio_rd_t               rd,
  output logic      [fdio_pkg::BYTE_W-1:0] rd_data,
  output logic                             rd_valid
);
  import fdio_pkg::*;

  // ****************************************************************
  // input filter
  // ****************************************************************
  // one counter per bit so a bouncing bit never holds back a quiet one
  logic [NUM_BITS-1:0] raw_q, raw_d;
  logic [NUM_BITS-1:0] in_q, in_d;
  logic [CNT_W-1:0]    cnt_q [NUM_BITS];
  logic [CNT_W-1:0]    cnt_d [NUM_BITS];

  always_comb
  begin
    raw_d = din_pins;
    in_d  = in_q;
    for (int i = 0; i < NUM_BITS; i++)
    begin
      cnt_d[i] = CNT_RESET;
      if (!filter_en)
      begin
        in_d[i] = raw_q[i];
      end
      else if (raw_q[i] != in_q[i])
      begin
        if (cnt_q[i] == FILT_LAST)
        begin
          in_d[i] = raw_q[i];
        end
        else
        begin
          cnt_d[i] = cnt_q[i] + CNT_W'(1);
        end
      end
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      raw_q <= IN_RESET;
      in_q  <= IN_RESET;
      for (int i = 0; i < NUM_BITS; i++)
        cnt_q[i] <= CNT_RESET;
    end
    else
    begin
      raw_q <= raw_d;
      in_q  <= in_d;
      for (int i = 0; i < NUM_BITS; i++)
        cnt_q[i] <= cnt_d[i];
    end
  end

  // ****************************************************************
  // reads
  // ****************************************************************
  logic [BYTE_W-1:0] rdata_q, rdata_d;
  logic              rvalid_q, rvalid_d;

  always_comb
  begin
    rdata_d  = rdata_q;
    rvalid_d = rd.bit_rd | rd.byte_rd;
    if (rd.byte_rd)
      rdata_d = {{(BYTE_W-NUM_BITS){1'b0}}, in_q};
    else if (rd.bit_rd)
      rdata_d = {{(BYTE_W-1){1'b0}}, in_q[rd.sel]};
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      rdata_q  <= BYTE_RESET;
      rvalid_q <= 1'b0;
    end
    else
    begin
      rdata_q  <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  assign rd_data  = rdata_q;
  assign rd_valid = rvalid_q;

  // ****************************************************************
  // outputs
  // ****************************************************************
  // byte write wins over a bit write in the same cycle; upper data bits are ignored
  logic [NUM_BITS-1:0] out_q, out_d;

  always_comb
  begin
    out_d = out_q;
    if (wr.byte_wr)
      out_d = wr.data[NUM_BITS-1:0];
    else if (wr.bit_wr)
      out_d[wr.sel] = wr.data[0];
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      out_q <= OUT_RESET;
    else
      out_q <= out_d;
  end

  assign dout_pins = out_q;

  // ****************************************************************
  // assertions
  // ****************************************************************
  property p_pin_sample;
    @(posedge clk) disable iff (reset)
    !filter_en ##1 !filter_en |=> in_q == $past(din_pins, 2);
  endproperty
  a_pin_sample: assert property (p_pin_sample) else $error("bypass input late");

  property p_bit_read;
    @(posedge clk) disable iff (reset)
    rd.bit_rd && !rd.byte_rd |=> rd_valid && rd_data == {7'h00, $past(in_q[rd.sel])};
  endproperty
  a_bit_read: assert property (p_bit_read) else $error("bit read wrong");

  property p_byte_read;
    @(posedge clk) disable iff (reset)
    rd.byte_rd |=> rd_valid && rd_data == {4'h0, $past(in_q)};
  endproperty
  a_byte_read: assert property (p_byte_read) else $error("byte read wrong");

  property p_filter_hold;
    @(posedge clk) disable iff (reset)
    filter_en && raw_q[0] != in_q[0] && cnt_q[0] == CNT_RESET |=> in_q[0] == $past(in_q[0]);
  endproperty
  a_filter_hold: assert property (p_filter_hold) else $error("filter passed early");

  property p_filter_pass;
    @(posedge clk) disable iff (reset)
    filter_en && raw_q[0] != in_q[0] && cnt_q[0] == FILT_LAST |=> in_q[0] == $past(raw_q[0]);
  endproperty
  a_filter_pass: assert property (p_filter_pass) else $error("filter did not pass");

  property p_pins_follow;
    @(posedge clk) disable iff (reset)
    !wr.bit_wr && !wr.byte_wr |=> dout_pins == $past(dout_pins);
  endproperty
  a_pins_follow: assert property (p_pins_follow) else $error("outputs moved unasked");

  property p_bit_write;
    @(posedge clk) disable iff (reset)
    wr.bit_wr && !wr.byte_wr && wr.sel == 2'h1 |=>
      dout_pins[1] == $past(wr.data[0]) && dout_pins[0] == $past(dout_pins[0])
      && dout_pins[3:2] == $past(dout_pins[3:2]);
  endproperty
  a_bit_write: assert property (p_bit_write) else $error("bit write wrong");

  property p_byte_write;
    @(posedge clk) disable iff (reset)
    wr.byte_wr |=> dout_pins == $past(wr.data[3:0]);
  endproperty
  a_byte_write: assert property (p_byte_write) else $error("byte write wrong");

  c_byte_write: cover property (@(posedge clk) disable iff (reset) wr.byte_wr ##1 rd.byte_rd);
  c_filter_pass: cover property (@(posedge clk) disable iff (reset)
    filter_en && cnt_q[0] == FILT_LAST && raw_q[0] != in_q[0]);
  c_bit_read: cover property (@(posedge clk) disable iff (reset) rd.bit_rd && rd.sel == 2'h3);

endmodule

// ### dv/fdio_pin_model.sv
// far side of the port: pin levels seen by the inputs, outputs watched
`timescale 1ns/1ns
module fdio_pin_model
  import fdio_pkg::*;
(
  // bench side
  input  wire logic [fdio_pkg::NUM_BITS-1:0] level,
  output logic      [fdio_pkg::NUM_BITS-1:0] seen,
  // pins
  output logic      [fdio_pkg::NUM_BITS-1:0] din_pins,
  input  wire logic [fdio_pkg::NUM_BITS-1:0] dout_pins
);
  // plain wires: the bench moves level only at the falling edge
  assign din_pins = level;
  assign seen     = dout_pins;
endmodule

// ### dv/testbench.sv
// self-checking bench for the four bit digital io port
`timescale 1ns/1ns
`define CHK(nm, ex, got) \
  begin \
    tests_run++; \
    if ((got) !== (ex)) \
    begin \
      miscompares++; \
      $display("FAIL %s expected %0h seen %0h", nm, ex, got); \
    end \
  end
module testbench;
  import fdio_pkg::*;
  // ****************************************************************
  // signals
  // ****************************************************************
  logic                clk;
  logic                reset;
  logic                filter_en;
  logic                rd_valid;
  logic [NUM_BITS-1:0] level;
  logic [NUM_BITS-1:0] seen;
  logic [NUM_BITS-1:0] din_pins;
  logic [NUM_BITS-1:0] dout_pins;
  logic [BYTE_W-1:0]   rd_data;
  fdio_wr_t            wr;
  fdio_rd_t            rd;
  int                  miscompares = 0;
  int                  tests_run = 0;
  int                  cycles = 0;
  fdio_port i_dut (.clk(clk), .reset(reset), .filter_en(filter_en), .din_pins(din_pins),
    .dout_pins(dout_pins), .wr(wr), .rd(rd), .rd_data(rd_data), .rd_valid(rd_valid));
  fdio_pin_model i_pins (.level(level), .seen(seen), .din_pins(din_pins),
    .dout_pins(dout_pins));
  // ****************************************************************
  // tasks
  // ****************************************************************
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  // one read; the pulse is looked at in the cycle after it is taken
  task automatic rd_chk(input logic bs, input logic [1:0] s, input logic [7:0] ex);
    rd = '{bit_rd: !bs, byte_rd: bs, sel: s};
    @(negedge clk);
    rd = '0;
    `CHK("rd_valid", 1'b1, rd_valid)
    `CHK("rd_data", ex, rd_data)
    @(negedge clk);
    `CHK("rd_valid_low", 1'b0, rd_valid)
  endtask
  task automatic wr_chk(input logic bs, input logic [1:0] s, input logic [7:0] d,
                        input logic [3:0] ex);
    wr = '{bit_wr: !bs, byte_wr: bs, sel: s, data: d};
    @(negedge clk);
    wr = '0;
    `CHK("dout_pins", ex, seen)
    // an idle edge, so the next call never re-raises a strobe in this time step
    @(negedge clk);
    `CHK("dout_hold", ex, seen)
  endtask
  task automatic t_out();
    wr_chk(1'b1, 2'h0, 8'hFA, 4'hA);
    wr_chk(1'b0, 2'h0, 8'h01, 4'hB);
    wr_chk(1'b0, 2'h2, 8'h01, 4'hF);
    wr_chk(1'b0, 2'h3, 8'h00, 4'h7);
    wr_chk(1'b0, 2'h1, 8'hFE, 4'h5);
    wr_chk(1'b1, 2'h0, 8'h00, 4'h0);
    $display("test t_out done");
  endtask
  // bypass: one pattern read whole and bit by bit
  task automatic t_in(input logic [3:0] v);
    level = v;
    cyc(4);
    rd_chk(1'b1, 2'h0, {4'h0, v});
    for (int i = 0; i < 4; i++)
      rd_chk(1'b0, 2'(i), {7'h00, v[i]});
    $display("test t_in done");
  endtask
  // a pulse shorter than the filter time never shows; a steady level does
  task automatic t_filt();
    filter_en = 1'b1;
    level = 4'hF;
    cyc(40);
    level = 4'h0;
    cyc(3);
    // the inputs still hold the last bypass value, neither the pulse nor the fall shows
    rd_chk(1'b1, 2'h0, 8'h0A);
    level = 4'h9;
    cyc(30);
    rd_chk(1'b1, 2'h0, 8'h0A);
    cyc(30);
    rd_chk(1'b1, 2'h0, 8'h09);
    filter_en = 1'b0;
    $display("test t_filt done");
  endtask
  // async reset mid-run: pins, answer and inputs drop at once, then bypass refills
  task automatic t_reset();
    wr_chk(1'b1, 2'h0, 8'h0F, 4'hF);
    reset = 1'b1;
    cyc(1);
    `CHK("rst_dout", 4'h0, seen)
    `CHK("rst_rd_data", 8'h00, rd_data)
    `CHK("rst_rd_valid", 1'b0, rd_valid)
    reset = 1'b0;
    rd_chk(1'b1, 2'h0, 8'h00);
    rd_chk(1'b1, 2'h0, {4'h0, level});
    $display("test t_reset done");
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // ****************************************************************
  // clock, timeout and sequence
  // ****************************************************************
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // the whole run needs well under a thousand cycles
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      miscompares++;
      end_of_test();
    end
  end
  initial
  begin
    reset = 1'b1;
    filter_en = 1'b0;
    level = 4'h0;
    wr = '0;
    rd = '0;
    cyc(2);
    reset = 1'b0;
    `CHK("reset_out", 4'h0, seen)
    t_out();
    t_in(4'h5);
    t_in(4'hA);
    t_filt();
    t_reset();
    end_of_test();
  end
endmodule
